// ### hw/ilm_pkg.sv
// shared types and constants for the indirect and literal move unit
`default_nettype none
package ilm_pkg;

	////////////////////////////////////////////////////////////////////////
	// widths
	localparam int ILM_DATA_W = 8;
	localparam int ILM_PTR_W = 16;
	localparam int ILM_BANK_W = 5;
	localparam int ILM_LATCH_W = 7;
	localparam int ILM_FADDR_W = 7;
	localparam int ILM_OFS_W = 6;

	////////////////////////////////////////////////////////////////////////
	// pointer_update_mode encodings
	localparam logic [1:0] ILM_MODE_PRE_INC = 2'h0;
	localparam logic [1:0] ILM_MODE_PRE_DEC = 2'h1;
	localparam logic [1:0] ILM_MODE_POST_INC = 2'h2;
	localparam logic [1:0] ILM_MODE_POST_DEC = 2'h3;

	// file addresses of the two indirect_access_port locations
	localparam logic [6:0] ILM_IND0_FADDR = 7'h00;
	localparam logic [6:0] ILM_IND1_FADDR = 7'h01;

	// values after reset, and the pointer step of one
	localparam logic [7:0] ILM_W_RST = 8'h00;
	localparam logic [4:0] ILM_BANK_RST = 5'h00;
	localparam logic [6:0] ILM_LATCH_RST = 7'h00;
	localparam logic [15:0] ILM_PTR_RST = 16'h0000;
	localparam logic [15:0] ILM_PTR_ONE = 16'h0001;

	////////////////////////////////////////////////////////////////////////
	// types
	typedef enum logic [2:0] {
		ILM_OP_NONE,
		ILM_OP_INDIRECT_LOAD_TO_WORKING,
		ILM_OP_INDIRECT_STORE_FROM_WORKING,
		ILM_OP_LOAD_BANK_IMMEDIATE,
		ILM_OP_LOAD_PROGRAM_LATCH_IMMEDIATE,
		ILM_OP_LOAD_WORKING_IMMEDIATE,
		ILM_OP_STORE_WORKING_TO_FILE
	} ilm_op_t;

	// decoded instruction; imm carries k or the file address
	typedef struct packed {
		ilm_op_t op;
		logic ptr_sel;
		logic [1:0] mode;
		logic rel;
		logic [5:0] offset;
		logic [7:0] imm;
	} ilm_cmd_t;

	typedef struct packed {
		logic req;
		logic we;
		logic [15:0] addr;
		logic [7:0] wdata;
	} ilm_mem_req_t;

endpackage
`default_nettype wire

// ### hw/ilm_ptr_unit.sv
// effective address and pointer update for one indirect move
`default_nettype none
module ilm_ptr_unit
	import ilm_pkg::*;
(
	// pointer and addressing form
	input wire logic [15:0] ptr,
	input wire logic [1:0] mode,
	input wire logic rel,
	input wire logic [5:0] offset,
	// results
	output logic [15:0] eff_addr,
	output logic [15:0] ptr_next
);

	logic [15:0] ofs_ext;
	logic [15:0] ptr_inc;
	logic [15:0] ptr_dec;

	// 16-bit sums drop the carry, so the pointer wraps both ways
	always_comb begin
		ofs_ext = {{10{offset[5]}}, offset};
		ptr_inc = ptr + ILM_PTR_ONE;
		ptr_dec = ptr - ILM_PTR_ONE;
		eff_addr = ptr;
		ptr_next = ptr;
		if (rel) begin
			eff_addr = ptr + ofs_ext;
			ptr_next = ptr;
		end else begin
			case (mode)
				ILM_MODE_PRE_INC: begin
					eff_addr = ptr_inc;
					ptr_next = ptr_inc;
				end
				ILM_MODE_PRE_DEC: begin
					eff_addr = ptr_dec;
					ptr_next = ptr_dec;
				end
				ILM_MODE_POST_INC: begin
					eff_addr = ptr;
					ptr_next = ptr_inc;
				end
				ILM_MODE_POST_DEC: begin
					eff_addr = ptr;
					ptr_next = ptr_dec;
				end
				default: begin
					eff_addr = ptr;
					ptr_next = ptr;
				end
			endcase
		end
	end

endmodule
`default_nettype wire

// ### hw/ilm_move_unit.sv
// execution unit for indirect and literal data-movement instructions
//
// Function
// - indirect moves copy between working and memory
// - two-bit mode selects pointer update kind
// - pre modes access pointer plus/minus one
// - offset form adds signed offset, pointer kept
// - pointer steps by one or stays after move
// - indirect file addresses redirect through pointer
// - pointers are 16 bits and wrap
// - pointer stepping leaves status flags alone
// - bank load writes 5-bit immediate
// - latch load writes 7-bit immediate
// - working load writes 8-bit immediate
// - file store writes working to file
`default_nettype none
module ilm_move_unit
	import ilm_pkg::*;
(
	// clock and reset
	input wire logic clock,
	input wire logic rstn,
	// decoded instruction
	input wire logic cmd_valid,
	input wire ilm_cmd_t cmd,
	output logic cmd_ready,
	// data memory
	output ilm_mem_req_t mem_q,
	input wire logic mem_rvalid,
	input wire logic [7:0] mem_rdata,
	// architectural state
	output logic [7:0] working_q,
	output logic zero_flag_q,
	output logic [4:0] bank_select_reg_q,
	output logic [6:0] program_counter_high_latch_q,
	output logic [15:0] file_pointer0_q,
	output logic [15:0] file_pointer1_q
);

	////////////////////////////////////////////////////////////////////////
	// state
	typedef enum logic {
		ILM_ST_IDLE,
		ILM_ST_READ
	} ilm_state_t;

	ilm_state_t state_q;
	ilm_state_t state_d;
	ilm_mem_req_t mem_d;
	logic [7:0] working_d;
	logic zero_flag_d;
	logic [4:0] bank_select_reg_d;
	logic [6:0] program_counter_high_latch_d;
	logic [15:0] file_pointer0_d;
	logic [15:0] file_pointer1_d;

	logic accept;
	logic [15:0] sel_ptr;
	logic [15:0] eff_addr;
	logic [15:0] ptr_next;
	logic [15:0] file_addr;
	logic is_indirect;

	////////////////////////////////////////////////////////////////////////
	// address arithmetic
	assign sel_ptr = cmd.ptr_sel ? file_pointer1_q : file_pointer0_q;

	ilm_ptr_unit u_ptr (
		.ptr(sel_ptr),
		.mode(cmd.mode),
		.rel(cmd.rel),
		.offset(cmd.offset),
		.eff_addr(eff_addr),
		.ptr_next(ptr_next)
	);

	// no ready while a read is out: a second move could overtake it
	assign cmd_ready = (state_q == ILM_ST_IDLE);
	assign accept = cmd_valid && cmd_ready;
	assign is_indirect = (cmd.op == ILM_OP_INDIRECT_LOAD_TO_WORKING) ||
		(cmd.op == ILM_OP_INDIRECT_STORE_FROM_WORKING);

	// bank forms the upper part of a direct file address
	always_comb begin
		file_addr = {4'h0, bank_select_reg_q, cmd.imm[6:0]};
		if (cmd.imm[6:0] == ILM_IND0_FADDR) begin
			file_addr = file_pointer0_q;
		end else if (cmd.imm[6:0] == ILM_IND1_FADDR) begin
			file_addr = file_pointer1_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// next state
	always_comb begin
		state_d = state_q;
		mem_d = '0;
		working_d = working_q;
		zero_flag_d = zero_flag_q;
		bank_select_reg_d = bank_select_reg_q;
		program_counter_high_latch_d = program_counter_high_latch_q;
		file_pointer0_d = file_pointer0_q;
		file_pointer1_d = file_pointer1_q;
		case (state_q)
			ILM_ST_IDLE: begin
				if (accept) begin
					case (cmd.op)
						ILM_OP_INDIRECT_LOAD_TO_WORKING: begin
							mem_d.req = 1'h1;
							mem_d.addr = eff_addr;
							state_d = ILM_ST_READ;
						end
						ILM_OP_INDIRECT_STORE_FROM_WORKING: begin
							mem_d.req = 1'h1;
							mem_d.we = 1'h1;
							mem_d.addr = eff_addr;
							mem_d.wdata = working_q;
						end
						ILM_OP_LOAD_BANK_IMMEDIATE: begin
							bank_select_reg_d = cmd.imm[4:0];
						end
						ILM_OP_LOAD_PROGRAM_LATCH_IMMEDIATE: begin
							program_counter_high_latch_d = cmd.imm[6:0];
						end
						ILM_OP_LOAD_WORKING_IMMEDIATE: begin
							working_d = cmd.imm;
						end
						ILM_OP_STORE_WORKING_TO_FILE: begin
							mem_d.req = 1'h1;
							mem_d.we = 1'h1;
							mem_d.addr = file_addr;
							mem_d.wdata = working_q;
						end
						default: begin
							state_d = ILM_ST_IDLE;
						end
					endcase
					// the step touches only the chosen pointer, never a flag
					if (is_indirect) begin
						if (cmd.ptr_sel) begin
							file_pointer1_d = ptr_next;
						end else begin
							file_pointer0_d = ptr_next;
						end
					end
				end
			end
			ILM_ST_READ: begin
				if (mem_rvalid) begin
					working_d = mem_rdata;
					zero_flag_d = (mem_rdata == 8'h00);
					state_d = ILM_ST_IDLE;
				end
			end
			default: begin
				state_d = ILM_ST_IDLE;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// registers
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			state_q <= ILM_ST_IDLE;
			mem_q <= '0;
			working_q <= ILM_W_RST;
			zero_flag_q <= 1'h0;
			bank_select_reg_q <= ILM_BANK_RST;
			program_counter_high_latch_q <= ILM_LATCH_RST;
			file_pointer0_q <= ILM_PTR_RST;
			file_pointer1_q <= ILM_PTR_RST;
		end else begin
			state_q <= state_d;
			mem_q <= mem_d;
			working_q <= working_d;
			zero_flag_q <= zero_flag_d;
			bank_select_reg_q <= bank_select_reg_d;
			program_counter_high_latch_q <= program_counter_high_latch_d;
			file_pointer0_q <= file_pointer0_d;
			file_pointer1_q <= file_pointer1_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	a_read_to_working: assert property (
		@(posedge clock) disable iff (!rstn)
		(state_q == ILM_ST_READ && mem_rvalid) |=>
			(working_q == $past(mem_rdata)) && cmd_ready)
		else $error("indirect read data not in working register");

	a_pre_inc_addr: assert property (
		@(posedge clock) disable iff (!rstn)
		(accept && is_indirect && !cmd.rel && !cmd.ptr_sel &&
			cmd.mode == ILM_MODE_PRE_INC) |=>
			mem_q.req && (mem_q.addr == 16'($past(file_pointer0_q) + 16'h0001)) &&
			(mem_q.addr == file_pointer0_q))
		else $error("pre-increment address wrong");

	a_rel_offset: assert property (
		@(posedge clock) disable iff (!rstn)
		(accept && is_indirect && cmd.rel && !cmd.ptr_sel) |=>
			$stable(file_pointer0_q) && (mem_q.addr == 16'($past(file_pointer0_q) +
			{{10{$past(cmd.offset[5])}}, $past(cmd.offset)})))
		else $error("relative offset access wrong");

	a_post_dec_step: assert property (
		@(posedge clock) disable iff (!rstn)
		(accept && is_indirect && !cmd.rel && cmd.ptr_sel &&
			cmd.mode == ILM_MODE_POST_DEC) |=>
			(mem_q.addr == $past(file_pointer1_q)) &&
			(file_pointer1_q == 16'($past(file_pointer1_q) - 16'h0001)))
		else $error("post-decrement step wrong");

	a_file_redirect: assert property (
		@(posedge clock) disable iff (!rstn)
		(accept && cmd.op == ILM_OP_STORE_WORKING_TO_FILE &&
			cmd.imm[6:0] == ILM_IND1_FADDR) |=>
			mem_q.we && (mem_q.addr == $past(file_pointer1_q)))
		else $error("indirect file address not redirected");

	a_flag_kept: assert property (
		@(posedge clock) disable iff (!rstn)
		(accept && cmd.op == ILM_OP_INDIRECT_STORE_FROM_WORKING) |=>
			$stable(zero_flag_q))
		else $error("pointer step changed a flag");

	a_bank_load: assert property (
		@(posedge clock) disable iff (!rstn)
		(accept && cmd.op == ILM_OP_LOAD_BANK_IMMEDIATE) |=>
			(bank_select_reg_q == $past(cmd.imm[4:0])) && !mem_q.req)
		else $error("bank load wrong");

	a_latch_load: assert property (
		@(posedge clock) disable iff (!rstn)
		(accept && cmd.op == ILM_OP_LOAD_PROGRAM_LATCH_IMMEDIATE) |=>
			program_counter_high_latch_q == $past(cmd.imm[6:0]))
		else $error("latch load wrong");

	a_working_load: assert property (
		@(posedge clock) disable iff (!rstn)
		(accept && cmd.op == ILM_OP_LOAD_WORKING_IMMEDIATE) |=>
			working_q == $past(cmd.imm))
		else $error("working load wrong");

	a_file_store: assert property (
		@(posedge clock) disable iff (!rstn)
		(accept && cmd.op == ILM_OP_STORE_WORKING_TO_FILE &&
			cmd.imm[6:0] != ILM_IND0_FADDR && cmd.imm[6:0] != ILM_IND1_FADDR) |=>
			mem_q.req && mem_q.we && (mem_q.wdata == $past(working_q)) &&
			(mem_q.addr == {4'h0, $past(bank_select_reg_q), $past(cmd.imm[6:0])}))
		else $error("file store wrong");

	a_other_ptr_kept: assert property (
		@(posedge clock) disable iff (!rstn)
		(accept && is_indirect && !cmd.ptr_sel) |=> $stable(file_pointer1_q))
		else $error("unselected pointer changed");

	a_wrap_top: assert property (
		@(posedge clock) disable iff (!rstn)
		(accept && is_indirect && !cmd.rel && !cmd.ptr_sel &&
			cmd.mode == ILM_MODE_POST_INC && file_pointer0_q == 16'hFFFF) |=>
			file_pointer0_q == 16'h0000)
		else $error("pointer did not wrap");

	a_wrap_bottom: assert property (
		@(posedge clock) disable iff (!rstn)
		(accept && is_indirect && !cmd.rel && !cmd.ptr_sel &&
			cmd.mode == ILM_MODE_POST_DEC && file_pointer0_q == 16'h0000) |=>
			file_pointer0_q == 16'hFFFF)
		else $error("pointer did not wrap below zero");

	a_pre_dec_addr: assert property (
		@(posedge clock) disable iff (!rstn)
		(accept && is_indirect && !cmd.rel && !cmd.ptr_sel &&
			cmd.mode == ILM_MODE_PRE_DEC) |=>
			mem_q.req && (mem_q.addr == 16'($past(file_pointer0_q) - 16'h0001)) &&
			(mem_q.addr == file_pointer0_q))
		else $error("pre-decrement address wrong");

	a_post_inc_step: assert property (
		@(posedge clock) disable iff (!rstn)
		(accept && is_indirect && !cmd.rel && cmd.ptr_sel &&
			cmd.mode == ILM_MODE_POST_INC) |=>
			(mem_q.addr == $past(file_pointer1_q)) &&
			(file_pointer1_q == 16'($past(file_pointer1_q) + 16'h0001)))
		else $error("post-increment step wrong");

	a_rel_second_ptr: assert property (
		@(posedge clock) disable iff (!rstn)
		(accept && is_indirect && cmd.rel && cmd.ptr_sel) |=>
			$stable(file_pointer1_q) && $stable(file_pointer0_q) &&
			(mem_q.addr == 16'($past(file_pointer1_q) +
			{{10{$past(cmd.offset[5])}}, $past(cmd.offset)})))
		else $error("second pointer offset access wrong");

	a_store_request: assert property (
		@(posedge clock) disable iff (!rstn)
		(accept && cmd.op == ILM_OP_INDIRECT_STORE_FROM_WORKING) |=>
			mem_q.req && mem_q.we && (mem_q.wdata == $past(working_q)) && cmd_ready)
		else $error("indirect store request wrong");

	// a load must stall the unit until its byte is back
	a_load_request: assert property (
		@(posedge clock) disable iff (!rstn)
		(accept && cmd.op == ILM_OP_INDIRECT_LOAD_TO_WORKING) |=>
			mem_q.req && !mem_q.we && !cmd_ready)
		else $error("indirect load request wrong");

	// a reply seen while idle belongs to no request
	a_idle_read_ignored: assert property (
		@(posedge clock) disable iff (!rstn)
		(state_q == ILM_ST_IDLE && !accept) |=> $stable(working_q))
		else $error("working register changed while idle");

endmodule
`default_nettype wire

// ### testbench/ilm_move_unit_tb_top.sv
// self-checking bench for the indirect and literal move unit
`default_nettype none
module ilm_move_unit_tb_top
	import ilm_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	////////////////////////////////////////////////////////////////////////
	// design hookup
	logic clock = 1'h0;
	logic rstn = 1'h0;
	logic cmd_valid = 1'h0;
	ilm_cmd_t cmd = '0;
	logic cmd_ready;
	ilm_mem_req_t mem_q;
	logic mem_rvalid = 1'h0;
	logic [7:0] mem_rdata = 8'h00;
	logic [7:0] working_q;
	logic zero_flag_q;
	logic [4:0] bank_select_reg_q;
	logic [6:0] program_counter_high_latch_q;
	logic [15:0] file_pointer0_q;
	logic [15:0] file_pointer1_q;
	int mismatches = 0;
	int compares = 0;
	int cycles = 0;
	// expected architectural state
	logic [15:0] p0 = 16'h0000;
	logic [15:0] p1 = 16'h0000;
	logic [7:0] w = 8'h00;
	logic z = 1'h0;
	logic [4:0] bk = 5'h00;
	logic [6:0] lt = 7'h00;

	ilm_move_unit dut (
		.clock(clock), .rstn(rstn), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready),
		.mem_q(mem_q), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata),
		.working_q(working_q), .zero_flag_q(zero_flag_q),
		.bank_select_reg_q(bank_select_reg_q),
		.program_counter_high_latch_q(program_counter_high_latch_q),
		.file_pointer0_q(file_pointer0_q), .file_pointer1_q(file_pointer1_q)
	);

	always #2.5 clock = ~clock;

	// a hung read wait ends the run here
	always @(posedge clock) begin
		cycles++;
		if (cycles == 3000) begin
			mismatches++;
			test_done();
		end
	end

	////////////////////////////////////////////////////////////////////////
	// shared tasks
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic test_done();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// drive at the falling edge, taken at the next rising edge
	task automatic issue(input ilm_op_t op, input logic s, input logic [1:0] m, input logic r,
			input logic [5:0] o, input logic [7:0] k);
		@(negedge clock);
		check(cmd_ready, 1'h1);
		cmd_valid = 1'h1;
		cmd = '{op, s, m, r, o, k};
		@(negedge clock);
		cmd_valid = 1'h0;
	endtask

	task automatic lit(input ilm_op_t op, input logic [7:0] k);
		issue(op, 1'h0, 2'h0, 1'h0, 6'h00, k);
	endtask

	task automatic state_chk();
		check(working_q, w);
		check(zero_flag_q, z);
		check(bank_select_reg_q, bk);
		check(program_counter_high_latch_q, lt);
		check(file_pointer0_q, p0);
		check(file_pointer1_q, p1);
	endtask

	// returns access address in the top half, next pointer in the bottom half
	function automatic logic [31:0] step(input logic [15:0] p, input logic [1:0] m,
			input logic r, input logic [5:0] o);
		logic [15:0] n;
		n = m[0] ? p - 16'h0001 : p + 16'h0001;
		if (r)
			return {p + {{10{o[5]}}, o}, p};
		return {m[1] ? p : n, n};
	endfunction

	task automatic ind(input logic ld, input logic s, input logic [1:0] m, input logic r,
			input logic [5:0] o, input logic [7:0] d, input int dly);
		logic [31:0] e;
		e = step(s ? p1 : p0, m, r, o);
		if (ld)
			issue(ILM_OP_INDIRECT_LOAD_TO_WORKING, s, m, r, o, 8'h00);
		else
			issue(ILM_OP_INDIRECT_STORE_FROM_WORKING, s, m, r, o, 8'h00);
		if (s) p1 = e[15:0];
		else p0 = e[15:0];
		check(mem_q.req, 1'h1);
		check(mem_q.we, !ld);
		check(mem_q.addr, e[31:16]);
		if (!ld) check(mem_q.wdata, w);
		if (ld) begin
			// unit must hold off new commands until the byte arrives
			repeat (dly) begin
				check(cmd_ready, 1'h0);
				@(negedge clock);
			end
			mem_rvalid = 1'h1;
			mem_rdata = d;
			@(negedge clock);
			mem_rvalid = 1'h0;
			mem_rdata = ~d;
			w = d;
			z = (d == 8'h00);
			check(cmd_ready, 1'h1);
		end
		state_chk();
	endtask

	////////////////////////////////////////////////////////////////////////
	// scenarios
	task automatic t_literal();
		lit(ILM_OP_LOAD_BANK_IMMEDIATE, 8'hff);
		bk = 5'h1f;
		check(mem_q.req, 1'h0);
		lit(ILM_OP_LOAD_PROGRAM_LATCH_IMMEDIATE, 8'hff);
		lt = 7'h7f;
		lit(ILM_OP_LOAD_WORKING_IMMEDIATE, 8'hff);
		w = 8'hff;
		state_chk();
		lit(ILM_OP_NONE, 8'h00);
		check(mem_q.req, 1'h0);
		// stray read reply while idle must not land in working
		mem_rvalid = 1'h1;
		mem_rdata = 8'h00;
		@(negedge clock);
		mem_rvalid = 1'h0;
		state_chk();
		$display("test literal done");
	endtask

	task automatic t_modes();
		logic [1:0] tbl [5] = '{2'h1, 2'h2, 2'h3, 2'h0, 2'h1};
		lit(ILM_OP_LOAD_WORKING_IMMEDIATE, 8'ha5);
		w = 8'ha5;
		foreach (tbl[i])
			ind(1'h0, 1'h0, tbl[i], 1'h0, 6'h00, 8'h00, 0);
		$display("test modes done");
	endtask

	task automatic t_loads();
		ind(1'h1, 1'h1, 2'h0, 1'h1, 6'h20, 8'h3c, 0);
		ind(1'h1, 1'h1, 2'h3, 1'h1, 6'h1f, 8'h5a, 3);
		ind(1'h1, 1'h1, 2'h2, 1'h0, 6'h00, 8'h00, 1);
		ind(1'h0, 1'h1, 2'h3, 1'h0, 6'h00, 8'h00, 0);
		$display("test loads done");
	endtask

	task automatic t_file();
		logic [6:0] fa [4] = '{7'h45, 7'h00, 7'h01, 7'h7f};
		lit(ILM_OP_LOAD_BANK_IMMEDIATE, 8'h02);
		bk = 5'h02;
		ind(1'h0, 1'h0, 2'h0, 1'h1, 6'h05, 8'h00, 0);
		foreach (fa[i]) begin
			lit(ILM_OP_STORE_WORKING_TO_FILE, {1'h0, fa[i]});
			check(mem_q.req, 1'h1);
			check(mem_q.we, 1'h1);
			check(mem_q.wdata, w);
			if (fa[i] == 7'h00) check(mem_q.addr, p0);
			else if (fa[i] == 7'h01) check(mem_q.addr, p1);
			else check(mem_q.addr, {4'h0, bk, fa[i]});
			state_chk();
		end
		$display("test file done");
	endtask

	initial begin
		repeat (5) @(posedge clock);
		@(negedge clock);
		rstn = 1'h1;
		check(cmd_ready, 1'h1);
		check(mem_q.req, 1'h0);
		state_chk();
		$display("test reset done");
		t_literal();
		t_modes();
		t_loads();
		t_file();
		test_done();
	end
endmodule
`default_nettype wire
